// File: logic/tpc_map.vh
// register map, field positions and reset values of the timer block
`ifndef TPC_MAP_VH
`define TPC_MAP_VH

`define TPC_ADDR_W        8
`define TPC_OFF_COUNT     8'h00
`define TPC_OFF_COMPARE   8'h04
`define TPC_OFF_MATCH     8'h08
`define TPC_OFF_INTFL     8'h0c
`define TPC_OFF_CTRL0     8'h10
`define TPC_OFF_CTRL1     8'h18

`define TPC_C0_MODE_MSB   3
`define TPC_C0_MODE_LSB   0
`define TPC_C0_PRES_MSB   7
`define TPC_C0_PRES_LSB   4
`define TPC_C0_POL        8
`define TPC_C0_EN         9
`define TPC_C0_OUTEN      10

`define TPC_C1_IRQEN      0
`define TPC_C1_CAPSEL_MSB 2
`define TPC_C1_CAPSEL_LSB 1
`define TPC_C1_W16        3

`define TPC_INTFL_PERIOD  0

`define TPC_MODE_PWM      4'h3
`define TPC_MODE_CAPTURE  4'h4
`define TPC_MODE_COMPARE  4'h5

`define TPC_CAP_RISE      2'h0
`define TPC_CAP_FALL      2'h1
`define TPC_CAP_BOTH      2'h2

`define TPC_RST_COUNT     32'h0000_0000
`define TPC_RST_COMPARE   32'hffff_ffff
`define TPC_RST_MATCH     32'h0000_0000
`define TPC_RELOAD        32'h0000_0001
`define TPC_W16_MASK      32'h0000_ffff

`endif

// File: logic/tpc_prescaler.v
// count enable generator: one pulse per 2**pres core clocks
`timescale 1ns/1ps
`default_nettype none
module tpc_prescaler #(
	parameter PRES_W = 4,
	parameter DIV_W  = 16
) (
	// clock and reset
	input  wire              core_clk,
	input  wire              resetn,
	// control
	input  wire              run,
	input  wire [PRES_W-1:0] pres,
	// count enable
	output reg               tick
);
	reg  [DIV_W-1:0] div;
	wire [DIV_W-1:0] lim;
	wire             last;

	assign lim  = ~({DIV_W{1'b1}} << pres);
	assign last = (div == lim);

	always @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			div  <= {DIV_W{1'b0}};
			tick <= 1'b0;
		end
		else if (!run)
		begin
			// restart so the first period is a whole interval
			div  <= {DIV_W{1'b0}};
			tick <= 1'b0;
		end
		else
		begin
			div  <= last ? {DIV_W{1'b0}} : div + {{(DIV_W-1){1'b0}}, 1'b1};
			tick <= last;
		end
	end
endmodule // tpc_prescaler
`default_nettype wire

// File: logic/tpc_in_sync.v
// two-flop synchroniser and edge detector for the timer input pin
`timescale 1ns/1ps
`default_nettype none
module tpc_in_sync (
	// clock and reset
	input  wire core_clk,
	input  wire resetn,
	// pin and edges
	input  wire pin_in,
	output reg  rise,
	output reg  fall
);
	reg meta;
	reg sync;
	reg last;

	always @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			meta <= 1'b0;
			sync <= 1'b0;
			last <= 1'b0;
			rise <= 1'b0;
			fall <= 1'b0;
		end
		else
		begin
			meta <= pin_in;
			sync <= meta;
			last <= sync;
			rise <= sync & ~last;
			fall <= ~sync & last;
		end
	end
endmodule // tpc_in_sync
`default_nettype wire

// File: logic/tpc_timer.v
// timer with pwm, capture and compare modes behind an apb slave
`timescale 1ns/1ps
`default_nettype none
`include "tpc_map.vh"
module tpc_timer #(
	parameter PRES_W = 4,
	parameter DIV_W  = 16
) (
	// clock and reset
	input  wire                   core_clk,
	input  wire                   resetn,
	// apb slave
	input  wire                   psel,
	input  wire                   penable,
	input  wire                   pwrite,
	input  wire [`TPC_ADDR_W-1:0] paddr,
	input  wire [31:0]            pwdata,
	output reg  [31:0]            prdata,
	output reg                    pready,
	output reg                    pslverr,
	// timer pins
	input  wire                   timer_in,
	output reg                    timer_out,
	output reg                    timer_out_oe,
	// interrupt request
	output reg                    irq_req
);
	// software-visible state
	reg  [31:0]       timer_count_value;
	reg  [31:0]       period_compare_value;
	reg  [31:0]       match_capture_value;
	reg               period_flag;
	reg  [3:0]        mode;
	reg  [PRES_W-1:0] pres;
	reg               pol;
	reg               enable;
	reg               outen;
	reg               irq_en;
	reg  [1:0]        cap_sel;
	reg               width16;

	// internal state
	reg               out_state;
	reg               cap_pending;

	// next values
	reg  [31:0]       next_count;
	reg  [31:0]       next_match;
	reg               next_flag;
	reg               next_out;
	reg               next_pending;

	// decoded strobes and events
	wire              setup;
	wire              wr;
	wire              tick;
	wire              in_rise;
	wire              in_fall;
	wire              cap_evt;
	wire              at_cmp;
	wire              at_match;
	wire              is_pwm;
	wire              is_cap;
	wire              is_cmp;
	wire              counting;
	wire              period_end;
	wire              cap_done;
	wire              flag_clr;

	function hit;
		input [`TPC_ADDR_W-1:0] a;
		begin
			case (a)
				`TPC_OFF_COUNT,
				`TPC_OFF_COMPARE,
				`TPC_OFF_MATCH,
				`TPC_OFF_INTFL,
				`TPC_OFF_CTRL0,
				`TPC_OFF_CTRL1: hit = 1'b1;
				default:        hit = 1'b0;
			endcase
		end
	endfunction

	// increment within the selected counter width
	function [31:0] bump;
		input [31:0] c;
		input        w16;
		begin
			if (w16)
				bump = (c + 32'h0000_0001) & `TPC_W16_MASK;
			else
				bump = c + 32'h0000_0001;
		end
	endfunction

	// counter width applied to a comparison operand
	function [31:0] fit;
		input [31:0] v;
		input        w16;
		begin
			fit = w16 ? (v & `TPC_W16_MASK) : v;
		end
	endfunction

	tpc_prescaler #(
		.PRES_W (PRES_W),
		.DIV_W  (DIV_W)
	) u_pres (
		.core_clk (core_clk),
		.resetn   (resetn),
		.run      (enable),
		.pres     (pres),
		.tick     (tick)
	);

	tpc_in_sync u_sync (
		.core_clk (core_clk),
		.resetn   (resetn),
		.pin_in   (timer_in),
		.rise     (in_rise),
		.fall     (in_fall)
	);

	assign setup = psel & ~penable;
	// pready is only ever high in an access phase, so this is the taking edge
	assign wr    = psel & penable & pready & pwrite;

	assign is_pwm   = (mode == `TPC_MODE_PWM);
	assign is_cap   = (mode == `TPC_MODE_CAPTURE);
	assign is_cmp   = (mode == `TPC_MODE_COMPARE);
	assign counting = enable & tick & (is_pwm | is_cap | is_cmp);

	assign at_cmp   = (fit(timer_count_value, width16) ==
	                   fit(period_compare_value, width16));
	assign at_match = (fit(timer_count_value, width16) ==
	                   fit(match_capture_value, width16));

	// capture source selection
	assign cap_evt = enable & is_cap &
	                 ((cap_sel == `TPC_CAP_RISE) & in_rise |
	                  (cap_sel == `TPC_CAP_FALL) & in_fall |
	                  (cap_sel == `TPC_CAP_BOTH) & (in_rise | in_fall));

	assign period_end = counting & at_cmp;
	assign cap_done   = counting & is_cap & cap_pending;
	assign flag_clr   = wr & (paddr == `TPC_OFF_INTFL) & pwdata[`TPC_INTFL_PERIOD];

	// counter
	always @*
	begin
		next_count = timer_count_value;
		if (wr && paddr == `TPC_OFF_COUNT)
			next_count = pwdata;
		else if (counting)
		begin
			case (mode)
				`TPC_MODE_PWM:
					// reload replaces any initial value after period one
					next_count = at_cmp ? `TPC_RELOAD
					                    : bump(timer_count_value, width16);
				`TPC_MODE_CAPTURE:
					// a pending capture does not touch the count
					next_count = at_cmp ? `TPC_RELOAD
					                    : bump(timer_count_value, width16);
				`TPC_MODE_COMPARE:
					next_count = bump(timer_count_value, width16);
				default:
					next_count = timer_count_value;
			endcase
		end
	end

	// match value and capture copy
	always @*
	begin
		next_match = match_capture_value;
		if (wr && paddr == `TPC_OFF_MATCH)
			next_match = pwdata;
		else if (cap_done)
			next_match = timer_count_value;
	end

	// capture waits for the next count clock; a new event wins over the clear
	always @*
	begin
		next_pending = cap_pending;
		if (!enable || !is_cap)
			next_pending = 1'b0;
		else if (cap_evt)
			next_pending = 1'b1;
		else if (cap_done)
			next_pending = 1'b0;
	end

	// period flag: a set in the clearing cycle is kept
	always @*
	begin
		next_flag = period_flag;
		if (flag_clr)
			next_flag = 1'b0;
		if (period_end || cap_done)
			next_flag = 1'b1;
	end

	// output waveform state; idles at the polarity level
	always @*
	begin
		next_out = out_state;
		if (!enable && wr && paddr == `TPC_OFF_CTRL0)
			// polarity written with the enable sets the start level at once
			next_out = pwdata[`TPC_C0_POL];
		else if (!enable)
			next_out = pol;
		else if (counting)
		begin
			case (mode)
				`TPC_MODE_PWM:
					if (at_cmp || at_match)
						next_out = ~out_state;
				`TPC_MODE_COMPARE:
					if (at_cmp)
						next_out = ~out_state;
				default:
					next_out = out_state;
			endcase
		end
	end

	// counting state
	always @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			timer_count_value   <= `TPC_RST_COUNT;
			match_capture_value <= `TPC_RST_MATCH;
			period_flag         <= 1'b0;
			out_state           <= 1'b0;
			cap_pending         <= 1'b0;
		end
		else
		begin
			timer_count_value   <= next_count;
			match_capture_value <= next_match;
			period_flag         <= next_flag;
			out_state           <= next_out;
			cap_pending         <= next_pending;
		end
	end

	// configuration registers
	always @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			period_compare_value <= `TPC_RST_COMPARE;
			mode                 <= 4'h0;
			pres                 <= {PRES_W{1'b0}};
			pol                  <= 1'b0;
			enable               <= 1'b0;
			outen                <= 1'b0;
			irq_en               <= 1'b0;
			cap_sel              <= 2'h0;
			width16              <= 1'b0;
		end
		else if (wr)
		begin
			case (paddr)
				`TPC_OFF_COMPARE:
					period_compare_value <= pwdata;
				`TPC_OFF_CTRL0:
				begin
					mode   <= pwdata[`TPC_C0_MODE_MSB:`TPC_C0_MODE_LSB];
					pres   <= pwdata[`TPC_C0_PRES_LSB+PRES_W-1:`TPC_C0_PRES_LSB];
					pol    <= pwdata[`TPC_C0_POL];
					enable <= pwdata[`TPC_C0_EN];
					outen  <= pwdata[`TPC_C0_OUTEN];
				end
				`TPC_OFF_CTRL1:
				begin
					irq_en  <= pwdata[`TPC_C1_IRQEN];
					cap_sel <= pwdata[`TPC_C1_CAPSEL_MSB:`TPC_C1_CAPSEL_LSB];
					width16 <= pwdata[`TPC_C1_W16];
				end
				default:
					period_compare_value <= period_compare_value;
			endcase
		end
	end

	// pin and interrupt outputs; the pin only follows while driven
	always @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			timer_out    <= 1'b0;
			timer_out_oe <= 1'b0;
			irq_req      <= 1'b0;
		end
		else
		begin
			if (outen)
				timer_out <= next_out;
			timer_out_oe <= outen;
			// level, so a second period end while set adds nothing
			irq_req      <= next_flag & irq_en;
		end
	end

	// apb answer: one wait-free access phase, data registered at setup
	always @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready  <= setup;
			pslverr <= setup & ~hit(paddr);
			if (setup && !pwrite)
			begin
				case (paddr)
					`TPC_OFF_COUNT:   prdata <= next_count;
					`TPC_OFF_COMPARE: prdata <= period_compare_value;
					`TPC_OFF_MATCH:   prdata <= next_match;
					`TPC_OFF_INTFL:   prdata <= {31'h0, next_flag};
					`TPC_OFF_CTRL0:
					begin
						prdata <= 32'h0000_0000;
						prdata[`TPC_C0_MODE_MSB:`TPC_C0_MODE_LSB] <= mode;
						prdata[`TPC_C0_PRES_LSB+PRES_W-1:`TPC_C0_PRES_LSB] <= pres;
						prdata[`TPC_C0_POL]   <= pol;
						prdata[`TPC_C0_EN]    <= enable;
						prdata[`TPC_C0_OUTEN] <= outen;
					end
					`TPC_OFF_CTRL1:
					begin
						prdata <= 32'h0000_0000;
						prdata[`TPC_C1_IRQEN] <= irq_en;
						prdata[`TPC_C1_CAPSEL_MSB:`TPC_C1_CAPSEL_LSB] <= cap_sel;
						prdata[`TPC_C1_W16]   <= width16;
					end
					default:          prdata <= 32'h0000_0000;
				endcase
			end
			else
				prdata <= 32'h0000_0000;
		end
	end
endmodule // tpc_timer
`default_nettype wire

// File: tb/tpc_timer_checker.sv
// port assertions for the timer block
`timescale 1ns/1ps
`default_nettype none
module tpc_timer_checker (
	// clock and reset
	input wire logic        core_clk,
	input wire logic        resetn,
	// apb
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// pins
	input wire logic        timer_in,
	input wire logic        timer_out,
	input wire logic        timer_out_oe,
	input wire logic        irq_req
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	wire unmapped = !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h18});
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_take;
		psel && penable && pready;
	endsequence
	chk_setup_ready: assert property (s_setup |=> pready) else $error("no ready after setup");
	chk_ready_cause: assert property (pready |-> $past(psel) && !$past(penable))
		else $error("ready without setup");
	chk_ready_pulse: assert property (pready |=> !pready) else $error("ready too long");
	chk_err_map: assert property (s_setup |=> pslverr == $past(unmapped))
		else $error("error flag wrong for address");
	chk_rdata_idle: assert property (!pready |-> prdata == 32'h0) else $error("stale read data");
	chk_oe_follow: assert property (
		s_take ##0 (pwrite && paddr == 8'h10) |=> ##1 timer_out_oe == $past(pwdata[10], 2))
		else $error("output enable not taken");
	chk_irq_off: assert property (
		s_take ##0 (pwrite && paddr == 8'h18 && !pwdata[0]) |=> ##1 !irq_req)
		else $error("interrupt while disabled");
	chk_out_gate: assert property ($changed(timer_out) |-> ##[0:1] timer_out_oe)
		else $error("pin moved while not driven");
endmodule // tpc_timer_checker
bind tpc_timer tpc_timer_checker u_chk (.core_clk, .resetn, .psel, .penable, .pwrite,
	.paddr, .pwdata, .prdata, .pready, .pslverr, .timer_in, .timer_out, .timer_out_oe,
	.irq_req);
`default_nettype wire

// File: tb/tpc_pin_model.sv
// far-side model of the timer input pin
`timescale 1ns/1ps
`default_nettype none
module tpc_pin_model (
	// clock
	input  wire logic core_clk,
	// request to change level
	input  wire logic flip,
	// pin into the timer
	output var  logic pin_level
);
	// level held between changes, far above the sync window
	initial pin_level = 1'b0;
	always @(posedge core_clk)
		if (flip)
			pin_level <= ~pin_level;
endmodule // tpc_pin_model
`default_nettype wire

// File: tb/tb_tpc_timer.sv
// self-checking bench for the timer block
`timescale 1ns/1ps
`default_nettype none
module tb_tpc_timer;
	logic        core_clk = 1'b0;
	logic        resetn   = 1'b0;
	logic        psel     = 1'b0;
	logic        penable  = 1'b0;
	logic        pwrite   = 1'b0;
	logic [7:0]  paddr    = 8'h00;
	logic [31:0] pwdata   = 32'h0;
	logic        flip     = 1'b0;
	wire  [31:0] prdata;
	wire         pready;
	wire         pslverr;
	wire         timer_in;
	wire         timer_out;
	wire         timer_out_oe;
	wire         irq_req;
	int          miscompares = 0;
	int          checked     = 0;
	logic [31:0] rd;
	logic [31:0] cnt;
	logic        err;
	int          n;
	always #25 core_clk = ~core_clk;
	tpc_timer DUT (.core_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .timer_in, .timer_out, .timer_out_oe, .irq_req);
	tpc_pin_model u_pin (.core_clk, .flip, .pin_level(timer_in));
	task automatic complete_run;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic bail;
		miscompares++;
		$display("FAIL %0t wait ran out", $time);
		complete_run;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			miscompares++;
			$display("FAIL %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge core_clk);
			n++;
		end
		while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1)
			bail;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// idle edge, so a following call never reassigns in this step
		@(posedge core_clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		cmp(rd, e);
	endtask
	task automatic run_len(input logic v, output int k);
		k = 0;
		do
		begin
			@(posedge core_clk);
			k++;
		end
		while (timer_out === v && k < 64);
		if (k >= 64)
			bail;
	endtask
	task automatic pwm(input logic pol);
		int k;
		wr(8'h10, 32'h0);
		wr(8'h04, 32'h5);
		wr(8'h08, 32'h2);
		wr(8'h00, 32'h0);
		wr(8'h18, 32'h1);
		wr(8'h10, {21'h0, 2'b11, pol, 8'h03});
		run_len(pol, k);
		run_len(~pol, k);
		cmp(k, 3);
		run_len(pol, k);
		cmp(k, 2);
		rdc(8'h0c, 32'h1);
		cmp({31'h0, irq_req}, 32'h1);
		wr(8'h10, 32'h0);
		apb(1'b0, 8'h00, 32'h0);
		cmp({31'h0, rd >= 1 && rd <= 5}, 32'h1);
		wr(8'h0c, 32'h1);
		rdc(8'h0c, 32'h0);
		cmp({31'h0, irq_req}, 32'h0);
		$display("end pwm");
	endtask
	initial
	begin
		repeat (12) @(posedge core_clk);
		resetn <= 1'b1;
		@(posedge core_clk);
		rdc(8'h00, 32'h0);
		rdc(8'h04, 32'hffff_ffff);
		apb(1'b0, 8'h14, 32'h0);
		cmp({rd[30:0], err}, 32'h1);
		$display("end reset");
		for (int p = 0; p < 2; p++)
			pwm(p[0]);
		// pin toggles each pass: rise, fall, rise under both, fall with no source
		for (int s = 0; s < 4; s++)
		begin
			wr(8'h10, 32'h0);
			wr(8'h0c, 32'h1);
			wr(8'h08, 32'h0);
			wr(8'h00, 32'h0);
			wr(8'h04, 32'hffff);
			wr(8'h18, {29'h0, s[1:0], 1'b1});
			wr(8'h10, 32'h204);
			repeat (20) @(posedge core_clk);
			flip <= 1'b1;
			@(posedge core_clk);
			flip <= 1'b0;
			repeat (20) @(posedge core_clk);
			apb(1'b0, 8'h08, 32'h0);
			cnt = rd;
			apb(1'b0, 8'h00, 32'h0);
			cmp({31'h0, cnt != 0 && cnt < rd}, {31'h0, s != 3});
			rdc(8'h0c, {31'h0, s != 3});
			cmp({31'h0, irq_req}, {31'h0, s != 3});
		end
		$display("end capture");
		wr(8'h10, 32'h0);
		wr(8'h0c, 32'h1);
		wr(8'h00, 32'h0);
		wr(8'h04, 32'h3);
		wr(8'h10, 32'h204);
		repeat (30) @(posedge core_clk);
		apb(1'b0, 8'h00, 32'h0);
		cmp({31'h0, rd >= 1 && rd <= 3}, 32'h1);
		rdc(8'h0c, 32'h1);
		$display("end rollover");
		wr(8'h10, 32'h400);
		wr(8'h0c, 32'h1);
		wr(8'h18, 32'h8);
		wr(8'h00, 32'hfff0);
		wr(8'h04, 32'hfff8);
		wr(8'h10, 32'h605);
		repeat (40) @(posedge core_clk);
		apb(1'b0, 8'h00, 32'h0);
		cmp({31'h0, rd < 32'h20}, 32'h1);
		rdc(8'h0c, 32'h1);
		cmp({31'h0, timer_out}, 32'h1);
		cmp({31'h0, irq_req}, 32'h0);
		$display("end compare");
		wr(8'h10, 32'h0);
		wr(8'h00, 32'h0);
		wr(8'h18, 32'h0);
		wr(8'h10, 32'h225);
		repeat (40) @(posedge core_clk);
		wr(8'h10, 32'h0);
		apb(1'b0, 8'h00, 32'h0);
		cmp({31'h0, rd >= 9 && rd <= 11}, 32'h1);
		$display("end prescale");
		complete_run;
	end
endmodule // tb_tpc_timer
`default_nettype wire
